// *** shared/ltic_pkg.sv ***
package ltic_pkg;
   // indicator layout, scan index equals physical scan position
   localparam int NUM_LEDS = 62;
   localparam int NUM_PROG = 48;
   localparam int NUM_STATUS = 12;
   localparam int TRIP_IDX = 0;
   localparam int ALARM_IDX = 1;
   localparam int STATUS_BASE = 2;
   localparam int PROG_BASE = 14;
   localparam int IDX_W = 6;
   // operand space and selectors
   localparam int N_OPS = 256;
   localparam int SEL_W = 8;
   // faceplate keys: three control buttons plus the target reset key
   localparam int NUM_BTNS = 3;
   localparam int NUM_KEYS = 4;
   localparam int RESET_KEY = 3;
   // timing
   localparam int CLOCK_MHZ = 250;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = TICK_US * CLOCK_MHZ;
   localparam int TICK_MS = TICK_US / 1000;
   localparam int STAGE1_LIMIT_MS = 60000;
   localparam int STEP_MS = 1000;
   localparam int QUAL_MS = 250;
   localparam int DROPOUT_MS = 100;
   localparam int STAGE1_TICKS = STAGE1_LIMIT_MS / TICK_MS;
   localparam int STEP_TICKS = STEP_MS / TICK_MS;
   localparam int QUAL_TICKS = QUAL_MS / TICK_MS;
   localparam int DROPOUT_TICKS = DROPOUT_MS / TICK_MS;
   localparam int TMR_W = 16;
   localparam logic [TMR_W-1:0] TMR_RESET = 16'h0000;
   localparam logic [IDX_W-1:0] IDX_RESET = 6'h00;
   localparam logic [NUM_LEDS-1:0] LEDS_RESET = 62'h0000_0000_0000_0000;
   typedef enum logic [1:0] {ST_IDLE, ST_ALL_ON, ST_WALK_ON, ST_WALK_OFF} ltic_stage_t;
endpackage : ltic_pkg

// *** src/ltic_button.sv ***
`timescale 1ns/1ns
`default_nettype none
module ltic_button #(
   parameter int DROP_TICKS = 100
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic tick,
   input wire logic press,
   output logic held,
   output logic press_evt
);
   import ltic_pkg::*;
   logic held_reg, held_next;
   logic prev_reg, prev_next;
   logic evt_reg, evt_next;
   logic [TMR_W-1:0] cnt_reg, cnt_next;

   // operand follows press, drops only after the dropout time
   always_comb
   begin
      held_next = held_reg;
      cnt_next = cnt_reg;
      prev_next = press;
      evt_next = press & ~prev_reg; // event on press edge only
      if (press)
      begin
         held_next = 1'b1;
         cnt_next = TMR_RESET;
      end
      else if (held_reg && tick)
      begin
         if (cnt_reg == TMR_W'(DROP_TICKS - 1))
            held_next = 1'b0;
         else
            cnt_next = cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         held_reg <= 1'b0;
         prev_reg <= 1'b0;
         evt_reg <= 1'b0;
         cnt_reg <= TMR_RESET;
      end
      else
      begin
         held_reg <= held_next;
         prev_reg <= prev_next;
         evt_reg <= evt_next;
         cnt_reg <= cnt_next;
      end
   end

   assign held = held_reg;
   assign press_evt = evt_reg;
endmodule : ltic_button
`default_nettype wire

// *** src/ltic_led_test.sv ***
// Notes on behaviour
// - test start enters stage one with all 62 indicators lit
// - stage one holds while control is on, ends test after 1 minute
// - stage two blanks all, lights one indicator at a time for 1 second
// - scan starts top-left, down each column, then next column
// - stage three lights all, darkens one at a time for 1 second
// - control release in stage one starts stage two
// - end of stage two scan moves straight into stage three
// - control rising edge in stage two or three aborts the test
// - control level and edges count only after 250 ms stable
// - test starts only when enabled; control operand is selectable
// - functional indicator states keep updating in shadow during a test
// - after test end or abort indicators show the shadow states
// - target reset key is ignored while a test runs
// - test-active flag stays set from start until end or abort
// - a test-initiated event is posted at start
// - trip and alarm indicators follow their selected operands
// - 48 programmable indicators, 1-24 panel two, 25-48 panel three
// - self-reset indicators follow their operand
// - latched indicators hold until faceplate, remote or operand reset
// - button operand set while pressed, drops 100 ms after release
// - event logged on button press, none on release
// - breaker manual control suppresses the button operands
`timescale 1ns/1ns
`default_nettype none
module ltic_led_test
   import ltic_pkg::*;
#(
   parameter int TICK_CYCLES = ltic_pkg::TICK_CYCLES
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic [ltic_pkg::N_OPS-1:0] OPERANDS,
   input wire logic TEST_FEATURE_ENABLE,
   input wire logic [ltic_pkg::SEL_W-1:0] TEST_TRIGGER_SOURCE,
   input wire logic [ltic_pkg::SEL_W-1:0] TRIP_SOURCE,
   input wire logic [ltic_pkg::SEL_W-1:0] ALARM_SOURCE,
   input wire logic [ltic_pkg::NUM_STATUS-1:0] STATUS_LEDS,
   input wire logic [ltic_pkg::NUM_PROG*ltic_pkg::SEL_W-1:0] PROG_SOURCE,
   input wire logic [ltic_pkg::NUM_PROG-1:0] INDICATOR_HOLD_TYPE,
   input wire logic [ltic_pkg::SEL_W-1:0] RESET_SOURCE,
   input wire logic REMOTE_RESET,
   input wire logic BREAKER_MANUAL_CTRL,
   input wire logic [ltic_pkg::NUM_KEYS-1:0] KEY_PINS,
   output logic [ltic_pkg::NUM_LEDS-1:0] LED_DRIVE,
   output logic TEST_ACTIVE_FLAG,
   output logic TEST_INIT_EVENT,
   output logic TARGET_RESET,
   output logic [ltic_pkg::NUM_BTNS-1:0] PANEL_BUTTON_PRESSED,
   output logic [ltic_pkg::NUM_BTNS-1:0] BUTTON_EVENT
);
   import ltic_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);

   function automatic logic sel_op(input logic [N_OPS-1:0] ops, input logic [SEL_W-1:0] sel);
      sel_op = ops[sel];
   endfunction : sel_op

   // lowest set key, used for key ownership
   function automatic logic [NUM_KEYS-1:0] lowest(input logic [NUM_KEYS-1:0] v);
      lowest = v & (~v + 1'b1);
   endfunction : lowest

   logic [NUM_KEYS-1:0] key_s1_reg, key_s2_reg;
   logic [NUM_KEYS-1:0] owner_reg, owner_next;
   logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
   logic tick_reg, tick_next;
   logic qual_reg, qual_next;
   logic qrise_reg, qrise_next;
   logic [TMR_W-1:0] qcnt_reg, qcnt_next;
   ltic_stage_t stage_reg, stage_next;
   logic [TMR_W-1:0] timer_reg, timer_next;
   logic [IDX_W-1:0] idx_reg, idx_next;
   logic init_reg, init_next;
   logic active_reg, active_next;
   logic [NUM_LEDS-1:0] shadow_reg, shadow_next;
   logic [NUM_LEDS-1:0] drive_reg, drive_next;
   logic tgt_reg, tgt_next;
   logic [NUM_KEYS-1:0] accepted;
   logic latch_clear;
   logic raw_ctrl;
   logic [NUM_LEDS-1:0] onehot;

   // key pins come from outside, two flops before any use
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         key_s1_reg <= '0;
         key_s2_reg <= '0;
      end
      else
      begin
         key_s1_reg <= KEY_PINS;
         key_s2_reg <= key_s1_reg;
      end
   end

   // one key owns the faceplate until it is released
   always_comb
   begin
      owner_next = owner_reg;
      if (owner_reg == '0)
         owner_next = lowest(key_s2_reg);
      else if ((owner_reg & key_s2_reg) == '0)
         owner_next = '0;
   end

   assign accepted = owner_reg & key_s2_reg;

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
         owner_reg <= '0;
      else
         owner_reg <= owner_next;
   end

   // common millisecond tick for every timer
   always_comb
   begin
      tick_next = 1'b0;
      tick_cnt_next = tick_cnt_reg + 1'b1;
      if (tick_cnt_reg == TW'(TICK_CYCLES - 1))
      begin
         tick_cnt_next = '0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_next;
         tick_reg <= tick_next;
      end
   end

   // control operand must stay changed for the qualify time to count
   assign raw_ctrl = sel_op(OPERANDS, TEST_TRIGGER_SOURCE);

   always_comb
   begin
      qual_next = qual_reg;
      qcnt_next = qcnt_reg;
      qrise_next = 1'b0;
      if (raw_ctrl == qual_reg)
         qcnt_next = TMR_RESET; // short glitch restarts the count
      else if (tick_reg)
      begin
         if (qcnt_reg == TMR_W'(QUAL_TICKS - 1))
         begin
            qual_next = raw_ctrl;
            qrise_next = raw_ctrl;
            qcnt_next = TMR_RESET;
         end
         else
            qcnt_next = qcnt_reg + 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         qual_reg <= 1'b0;
         qrise_reg <= 1'b0;
         qcnt_reg <= TMR_RESET;
      end
      else
      begin
         qual_reg <= qual_next;
         qrise_reg <= qrise_next;
         qcnt_reg <= qcnt_next;
      end
   end

   // test sequencer
   always_comb
   begin
      stage_next = stage_reg;
      timer_next = timer_reg;
      idx_next = idx_reg;
      init_next = 1'b0;
      unique case (stage_reg)
         ST_IDLE:
         begin
            timer_next = TMR_RESET;
            idx_next = IDX_RESET;
            if (TEST_FEATURE_ENABLE && qrise_reg)
            begin
               stage_next = ST_ALL_ON;
               init_next = 1'b1;
            end
         end
         ST_ALL_ON:
         begin
            if (!qual_reg)
            begin
               stage_next = ST_WALK_ON;
               timer_next = TMR_RESET;
               idx_next = IDX_RESET;
            end
            else if (tick_reg)
            begin
               if (timer_reg == TMR_W'(STAGE1_TICKS - 1))
                  stage_next = ST_IDLE;
               else
                  timer_next = timer_reg + 1'b1;
            end
         end
         ST_WALK_ON, ST_WALK_OFF:
         begin
            if (qrise_reg)
               stage_next = ST_IDLE;
            else if (tick_reg)
            begin
               if (timer_reg == TMR_W'(STEP_TICKS - 1))
               begin
                  timer_next = TMR_RESET;
                  if (idx_reg == IDX_W'(NUM_LEDS - 1))
                  begin
                     idx_next = IDX_RESET;
                     // walk-on runs straight into walk-off
                     stage_next = (stage_reg == ST_WALK_ON) ? ST_WALK_OFF : ST_IDLE;
                  end
                  else
                     idx_next = idx_reg + 1'b1;
               end
               else
                  timer_next = timer_reg + 1'b1;
            end
         end
      endcase
      // dropping the feature mid-test ends it cleanly
      if (!TEST_FEATURE_ENABLE)
         stage_next = ST_IDLE;
      active_next = (stage_next != ST_IDLE);
   end

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         stage_reg <= ST_IDLE;
         timer_reg <= TMR_RESET;
         idx_reg <= IDX_RESET;
         init_reg <= 1'b0;
         active_reg <= 1'b0;
      end
      else
      begin
         stage_reg <= stage_next;
         timer_reg <= timer_next;
         idx_reg <= idx_next;
         init_reg <= init_next;
         active_reg <= active_next;
      end
   end

   // reset key is blocked during a test so targets survive it
   assign latch_clear = (accepted[RESET_KEY] & ~active_reg)
      | REMOTE_RESET | sel_op(OPERANDS, RESET_SOURCE);

   // functional indicator state, kept live even while a test drives the panel
   always_comb
   begin
      shadow_next = shadow_reg;
      shadow_next[TRIP_IDX] = sel_op(OPERANDS, TRIP_SOURCE);
      shadow_next[ALARM_IDX] = sel_op(OPERANDS, ALARM_SOURCE);
      shadow_next[STATUS_BASE +: NUM_STATUS] = STATUS_LEDS;
      for (int i = 0; i < NUM_PROG; i++)
      begin
         // an operand still high at clear keeps the indicator lit
         if (INDICATOR_HOLD_TYPE[i])
            shadow_next[PROG_BASE + i] = (shadow_reg[PROG_BASE + i] & ~latch_clear)
               | sel_op(OPERANDS, PROG_SOURCE[i*SEL_W +: SEL_W]);
         else
            shadow_next[PROG_BASE + i] = sel_op(OPERANDS, PROG_SOURCE[i*SEL_W +: SEL_W]);
      end
   end

   assign onehot = NUM_LEDS'(1) << idx_reg;

   // panel drive: test pattern while running, shadow states otherwise
   always_comb
   begin
      unique case (stage_reg)
         ST_IDLE: drive_next = shadow_reg;
         ST_ALL_ON: drive_next = ~LEDS_RESET;
         ST_WALK_ON: drive_next = onehot;
         ST_WALK_OFF: drive_next = ~onehot;
      endcase
      tgt_next = latch_clear;
   end

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         shadow_reg <= LEDS_RESET;
         drive_reg <= LEDS_RESET;
         tgt_reg <= 1'b0;
      end
      else
      begin
         shadow_reg <= shadow_next;
         drive_reg <= drive_next;
         tgt_reg <= tgt_next;
      end
   end

   // control buttons, suppressed when assigned to breaker control
   for (genvar b = 0; b < NUM_BTNS; b++)
   begin : g_btn
      ltic_button #(
         .DROP_TICKS(DROPOUT_TICKS)
      ) u_btn (
         .clk(CLOCK),
         .arst_n(ARST_N),
         .tick(tick_reg),
         .press(accepted[b] & ~BREAKER_MANUAL_CTRL),
         .held(PANEL_BUTTON_PRESSED[b]),
         .press_evt(BUTTON_EVENT[b])
      );
   end

   assign LED_DRIVE = drive_reg;
   assign TEST_ACTIVE_FLAG = active_reg;
   assign TEST_INIT_EVENT = init_reg;
   assign TARGET_RESET = tgt_reg;
endmodule : ltic_led_test
`default_nettype wire

// *** tb/ltic_led_test_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module ltic_led_test_asserts
   import ltic_pkg::*;
#(
   parameter int TICK_CYCLES = 10
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic TEST_FEATURE_ENABLE,
   input wire logic BREAKER_MANUAL_CTRL,
   input wire logic REMOTE_RESET,
   input wire logic [ltic_pkg::N_OPS-1:0] OPERANDS,
   input wire logic [ltic_pkg::SEL_W-1:0] RESET_SOURCE,
   input wire logic [ltic_pkg::NUM_KEYS-1:0] KEY_PINS,
   input wire logic [ltic_pkg::NUM_LEDS-1:0] LED_DRIVE,
   input wire logic TEST_ACTIVE_FLAG,
   input wire logic TEST_INIT_EVENT,
   input wire logic TARGET_RESET,
   input wire logic [ltic_pkg::NUM_BTNS-1:0] PANEL_BUTTON_PRESSED,
   input wire logic [ltic_pkg::NUM_BTNS-1:0] BUTTON_EVENT
);
   import ltic_pkg::*;
   localparam int DROP_MIN = (DROPOUT_TICKS - 1) * TICK_CYCLES;
   localparam int DROP_MAX = (DROPOUT_TICKS + 2) * TICK_CYCLES;
   logic [31:0] low_cnt_reg;
   logic [31:0] low_cnt_next;
   // cycles since key 0 let go, saturating so long idles stay legal
   always_comb
   begin
      low_cnt_next = 32'h0000_0000;
      if (!KEY_PINS[0] && low_cnt_reg != 32'hFFFF_FFFF)
      begin
         low_cnt_next = low_cnt_reg + 32'h0000_0001;
      end
      else if (!KEY_PINS[0])
      begin
         low_cnt_next = low_cnt_reg;
      end
   end
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         low_cnt_reg <= 32'h0000_0000;
      end
      else
      begin
         low_cnt_reg <= low_cnt_next;
      end
   end
   // output checks, all on the one block clock
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   a_init_all_on: assert property (TEST_INIT_EVENT |=> LED_DRIVE == {NUM_LEDS{1'b1}})
      else $error("indicators not all lit after start");
   a_init_pulse_once: assert property (TEST_INIT_EVENT |=> !TEST_INIT_EVENT)
      else $error("start event longer than one cycle");
   a_init_with_active: assert property (TEST_INIT_EVENT |-> TEST_ACTIVE_FLAG && !$past(TEST_ACTIVE_FLAG))
      else $error("active flag not raised with start event");
   a_enable_low_stops: assert property (!TEST_FEATURE_ENABLE [*3] |-> !TEST_ACTIVE_FLAG)
      else $error("test runs while disabled");
   // remote and operand resets may still clear during a test, only the key is blocked
   a_key_blocked: assert property (TEST_ACTIVE_FLAG [*5] ##0 (!$past(REMOTE_RESET)
      && !$past(OPERANDS[RESET_SOURCE])) |-> !TARGET_RESET)
      else $error("target reset during test");
   a_event_one_key: assert property ($onehot0(BUTTON_EVENT))
      else $error("two button events at once");
   a_event_pulse: assert property (BUTTON_EVENT != 3'h0 |=> BUTTON_EVENT == 3'h0)
      else $error("button event longer than one cycle");
   a_breaker_quiet: assert property (BREAKER_MANUAL_CTRL [*3] |->
      PANEL_BUTTON_PRESSED == 3'h0 && BUTTON_EVENT == 3'h0)
      else $error("button operand under breaker control");
   a_dropout_time: assert property ($fell(PANEL_BUTTON_PRESSED[0]) && !BREAKER_MANUAL_CTRL |->
      low_cnt_reg >= DROP_MIN && low_cnt_reg <= DROP_MAX)
      else $error("button dropout time wrong");
   // drive lags the stage by one cycle, hence the past active terms
   a_walk_pattern: assert property ($past(TEST_ACTIVE_FLAG) |->
      LED_DRIVE == {NUM_LEDS{1'b1}} || $onehot(LED_DRIVE) || $onehot(~LED_DRIVE))
      else $error("test pattern not all lit, one lit or one dark");
   a_scan_order: assert property ($past(TEST_ACTIVE_FLAG) && $past(TEST_ACTIVE_FLAG, 2)
      && $onehot(LED_DRIVE) && $onehot($past(LED_DRIVE)) && LED_DRIVE != $past(LED_DRIVE) |->
      LED_DRIVE == ($past(LED_DRIVE) << 1))
      else $error("scan did not step to the next indicator");
   // main scenarios reached
   c_start: cover property (TEST_INIT_EVENT);
   c_end: cover property ($fell(TEST_ACTIVE_FLAG));
   c_press: cover property (BUTTON_EVENT[0]);
endmodule : ltic_led_test_asserts
bind ltic_led_test ltic_led_test_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.CLOCK(CLOCK),
   .ARST_N(ARST_N), .TEST_FEATURE_ENABLE(TEST_FEATURE_ENABLE), .KEY_PINS(KEY_PINS),
   .BREAKER_MANUAL_CTRL(BREAKER_MANUAL_CTRL), .LED_DRIVE(LED_DRIVE), .TARGET_RESET(TARGET_RESET),
   .REMOTE_RESET(REMOTE_RESET), .OPERANDS(OPERANDS), .RESET_SOURCE(RESET_SOURCE),
   .TEST_ACTIVE_FLAG(TEST_ACTIVE_FLAG), .TEST_INIT_EVENT(TEST_INIT_EVENT),
   .PANEL_BUTTON_PRESSED(PANEL_BUTTON_PRESSED), .BUTTON_EVENT(BUTTON_EVENT));
`default_nettype wire

// *** tb/ltic_panel_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module ltic_panel_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] key_req,
   input wire logic [61:0] led,
   output logic [3:0] key_pins,
   output logic [6:0] lit
);
   logic [3:0] key_reg;
   logic [3:0] key_next;
   // fingers move just after an edge; raw keys reach the pins unsynced
   always_comb
   begin
      key_next = key_req;
   end
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         key_reg <= 4'h0;
      end
      else
      begin
         key_reg <= key_next;
      end
   end
   assign key_pins = key_reg;
   // how many lamps glow, as an eye on the panel would count
   assign lit = 7'($countones(led));
endmodule : ltic_panel_model
`default_nettype wire

// *** tb/led_test_and_indicator_control_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module led_test_and_indicator_control_tb;
   import ltic_pkg::*;
   localparam logic [61:0] MASK = 62'h3FFF_FFFF_FFFF_BFFF;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [255:0] ops;
   logic [383:0] psrc;
   logic [47:0] hold;
   logic [11:0] status;
   logic [7:0] trig, trip, alarm, rsrc;
   logic en, brk, rem;
   logic [3:0] key_req, key_pins;
   logic [61:0] led;
   logic [6:0] lit;
   logic act, init, trst;
   logic [2:0] pressed, bev;
   logic [15:0] seed = 16'h0055;
   int errors = 0;
   int check_count = 0;
   int ev_count = 0;
   int t;
   ltic_led_test #(.TICK_CYCLES(10)) dut (.CLOCK(clk), .ARST_N(arst_n), .OPERANDS(ops),
      .TEST_FEATURE_ENABLE(en), .TEST_TRIGGER_SOURCE(trig), .TRIP_SOURCE(trip),
      .ALARM_SOURCE(alarm), .STATUS_LEDS(status), .PROG_SOURCE(psrc),
      .INDICATOR_HOLD_TYPE(hold), .RESET_SOURCE(rsrc), .REMOTE_RESET(rem),
      .BREAKER_MANUAL_CTRL(brk), .KEY_PINS(key_pins), .LED_DRIVE(led),
      .TEST_ACTIVE_FLAG(act), .TEST_INIT_EVENT(init), .TARGET_RESET(trst),
      .PANEL_BUTTON_PRESSED(pressed), .BUTTON_EVENT(bev));
   ltic_panel_model panel (.clk(clk), .arst_n(arst_n), .key_req(key_req), .led(led),
      .key_pins(key_pins), .lit(lit));
   always #2 clk = ~clk;
   // every button event seen, to prove none comes on release
   always @(posedge clk)
   begin
      if (bev !== 3'h0)
      begin
         ev_count <= ev_count + 1;
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // self-reset indicators straight from their operands; slot 0 is latched
   function automatic logic [61:0] exp_led();
      logic [61:0] e;
      e[0] = ops[trip];
      e[1] = ops[alarm];
      e[13:2] = status;
      for (int i = 0; i < NUM_PROG; i++)
      begin
         e[PROG_BASE + i] = ops[psrc[i*8 +: 8]];
      end
      return e;
   endfunction : exp_led
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task stop_test();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   task chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk
   // bounded wait on the lamp pattern (sel 0) or the active flag (sel 1)
   task waitfor(input int sel, input logic [61:0] v, input int lim, output int n);
      for (n = 0; n < lim; n++)
      begin
         @(posedge clk);
         #1;
         if ((sel == 0 && led === v) || (sel == 1 && act === v[0]))
         begin
            break;
         end
      end
      if (n == lim)
      begin
         errors++;
         $display("wrong value at %0t: wait ran out", $time);
         stop_test();
      end
   endtask : waitfor
   // low operands random, sources kept below the control operands
   task rand_in();
      for (int k = 0; k < 8; k++)
      begin
         seed = lfsr(seed);
         ops[k*16 +: 16] <= seed;
      end
      for (int i = 1; i < NUM_PROG; i++)
      begin
         seed = lfsr(seed);
         psrc[i*8 +: 8] <= {1'b0, seed[6:0]};
      end
      seed = lfsr(seed);
      trip <= {1'b0, seed[6:0]};
      alarm <= {1'b0, seed[14:8]};
      seed = lfsr(seed);
      status <= seed[11:0];
   endtask : rand_in
   initial
   begin
      ops = '0;
      psrc = '0;
      psrc[7:0] = 8'hFB;
      hold = 48'h0000_0000_0001;
      status = 12'h000;
      trig = 8'hFA;
      trip = 8'h00;
      alarm = 8'h01;
      rsrc = 8'hFC;
      en = 1'b0;
      brk = 1'b0;
      rem = 1'b0;
      key_req = 4'h0;
      cyc(15);
      @(posedge clk);
      arst_n <= 1'b1;
      repeat (4)
      begin
         @(posedge clk);
         rand_in();
         cyc(4);
         chk((led & MASK) === (exp_led() & MASK), "idle indicators");
      end
      @(posedge clk);
      ops[250] <= 1'b1;
      cyc(3000);
      chk(act === 1'b0, "start while disabled");
      @(posedge clk);
      ops[250] <= 1'b0;
      cyc(3000);
      @(posedge clk);
      en <= 1'b1;
      ops[250] <= 1'b1;
      waitfor(1, 62'h1, 4000, t);
      chk(init === 1'b1, "start event");
      cyc(1);
      chk(led === {NUM_LEDS{1'b1}} && init === 1'b0, "all on");
      @(posedge clk);
      ops[250] <= 1'b0;
      cyc(1000);
      @(posedge clk);
      ops[250] <= 1'b1;
      ops[251] <= 1'b1;
      key_req[3] <= 1'b1;
      cyc(2000);
      chk(led === {NUM_LEDS{1'b1}} && act === 1'b1 && trst === 1'b0, "short drop");
      @(posedge clk);
      ops[251] <= 1'b0;
      key_req[3] <= 1'b0;
      ops[250] <= 1'b0;
      waitfor(0, 62'h1, 4000, t);
      chk(lit === 7'h01, "walk start");
      waitfor(0, 62'h2, 10100, t);
      chk(t >= 9990 && t <= 10010, "step time");
      @(posedge clk);
      ops[250] <= 1'b1;
      waitfor(1, 62'h0, 4000, t);
      cyc(3);
      chk((led & MASK) === (exp_led() & MASK) && led[14] === 1'b1, "shadow");
      @(posedge clk);
      key_req[3] <= 1'b1;
      cyc(10);
      chk(trst === 1'b1, "target reset");
      @(posedge clk);
      key_req[3] <= 1'b0;
      cyc(10);
      chk(led[14] === 1'b0, "latch clear");
      // latch again, then clear it remotely and from the reset operand
      @(posedge clk);
      ops[251] <= 1'b1;
      cyc(4);
      @(posedge clk);
      ops[251] <= 1'b0;
      cyc(4);
      chk(led[14] === 1'b1, "latch hold");
      @(posedge clk);
      rem <= 1'b1;
      cyc(4);
      chk(led[14] === 1'b0 && trst === 1'b1, "remote clear");
      @(posedge clk);
      rem <= 1'b0;
      ops[251] <= 1'b1;
      cyc(4);
      @(posedge clk);
      ops[251] <= 1'b0;
      ops[252] <= 1'b1;
      cyc(4);
      chk(led[14] === 1'b0 && trst === 1'b1, "operand clear");
      @(posedge clk);
      ops[252] <= 1'b0;
      cyc(4);
      @(posedge clk);
      key_req[0] <= 1'b1;
      cyc(8);
      chk(pressed === 3'h1 && ev_count === 1, "press");
      @(posedge clk);
      key_req[1] <= 1'b1;
      cyc(8);
      chk(pressed === 3'h1, "second key");
      @(posedge clk);
      key_req <= 4'h0;
      cyc(900);
      chk(pressed[0] === 1'b1, "dropout hold");
      cyc(200);
      chk(pressed === 3'h0 && ev_count === 1, "dropout end");
      @(posedge clk);
      brk <= 1'b1;
      key_req[2] <= 1'b1;
      cyc(10);
      chk(pressed === 3'h0 && ev_count === 1, "breaker control");
      stop_test();
   end
endmodule : led_test_and_indicator_control_tb
`default_nettype wire
